// >>> rtl/utx_core.sv
// Transmit path, holding and shift registers plus upper register map
// Function
// [R01] 256-byte FIFO, holding register, shift register
// [R02] FIFO enable routes writes through FIFO
// [R03] Each bit lasts 16 or 8 ticks
// [R04] Start, data, optional parity, stop bits
// [R05] Data leaves least significant bit first
// [R06] Non-FIFO: holding empty set on transfer
// [R07] Shifter empty only after stop bits
// [R08] Tx empty interrupt only when enabled
// [R09] Host may queue 256 bytes
// [R10] FIFO mode: holding empty when FIFO empty
// [R11] FIFO interrupt when level below threshold
// [R12] Half-duplex: interrupt follows shifter empty
// [R13] Direction held until last stop bit
// [R14] Feature, tx level, rx level registers
// [R15] Flow characters write-only, status read back
// [R16] Flow status upper zeros, clears on read
// [R17] Enhanced bits gated by feature bit four
// [R18] Feature bits steer flow control modes
// [R19] Spare outputs drive no pins
// [R20] Direction released after programmed delay
// [R21] Direction polarity selectable
// [R22] Shifter-empty flag needs FIFO empty too
// [R23] Write to full FIFO is dropped
// [R24] Fill count saturates, tracks push/pop
module utx_core #(
	parameter int DEPTH = 256 // Tx FIFO entries
) (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire logic [3:0]            addr,
	input  wire logic                  wr_en,
	input  wire logic                  rd_en,
	input  wire logic [7:0]            wdata,
	output logic      [7:0]            rdata,
	input  wire utx_pkg::utx_cfg_t     cfg,
	input  wire utx_pkg::utx_flow_ev_t flow_ev,
	input  wire logic [7:0]            rx_fill_count,
	input  wire logic                  baud_tick,
	output logic                       txd,
	output logic                       loop_txd,
	output logic [1:0]                 loop_spare,
	output logic                       dir_out,
	output logic                       thr_empty,
	output logic                       tsr_empty,
	output logic                       tx_int,
	output logic                       enh_enable,
	output logic                       auto_cts_en,
	output logic                       auto_rts_en,
	output logic                       special_char_en,
	output logic [3:0]                 sw_flow_mode,
	output logic [7:0]                 rx_fifo_threshold,
	output logic [7:0]                 stop_char_first,
	output logic [7:0]                 stop_char_second,
	output logic [7:0]                 resume_char_first,
	output logic [7:0]                 resume_char_second
);

	localparam int AW = $clog2(DEPTH); // Pointer width

	// Storage and state
	logic [7:0]            fifo_mem [DEPTH];     // Tx FIFO array
	logic [AW-1:0]         wr_ptr_r;             // Write pointer
	logic [AW-1:0]         rd_ptr_r;             // Read pointer
	logic [AW:0]           count_r;              // Bytes queued
	logic [7:0]            tx_holding_reg_r;     // Holding register
	logic                  holding_full_r;       // Holding register occupied
	logic [utx_pkg::FRAME_W-1:0] tx_shift_reg_r; // Shift register with framing
	logic [3:0]            bits_left_r;          // Bits still to send
	logic [3:0]            tick_cnt_r;           // Ticks within current bit
	utx_pkg::utx_state_t   state_r;              // Shifter state
	logic                  dir_active_r;         // Direction in transmit state
	logic [3:0]            dly_cnt_r;            // Turn-around bit counter
	logic [7:0]            efc_r;                // Enhanced feature control
	logic [7:0]            tx_threshold_r;       // Tx trigger level
	logic [7:0]            rx_threshold_r;       // Rx trigger level
	logic [7:0]            stop1_r;              // First stop character
	logic [7:0]            stop2_r;              // Second stop character
	logic [7:0]            resume1_r;            // First resume character
	logic [7:0]            resume2_r;            // Second resume character
	logic [3:0]            flow_flags_r;         // Sticky flow indicators
	logic [7:0]            rdata_r;              // Read data
	logic                  txd_r;                // Serial output
	logic [1:0]            loop_spare_r;         // Spare bits seen by loopback

	// Decoded strobes
	logic       holding_wr;    // Host write to holding register
	logic       fifo_push;     // Byte accepted into FIFO
	logic       fifo_pop;      // Byte moved FIFO to holding
	logic       fifo_empty;    // No bytes queued
	logic       shift_load;    // Holding moves into shifter
	logic       bit_end;       // Last tick of a bit time
	logic       flow_rd;       // Read of flow status
	logic [3:0] tick_last;     // Tick count of last tick in a bit
	logic [7:0] fill_sat;      // Saturated fill count

	// Frame builder: start, data lsb first, parity, stops
	function automatic logic [utx_pkg::FRAME_W-1:0] build_frame(
		input logic [7:0]       d,
		input utx_pkg::utx_cfg_t c
	);
		logic [utx_pkg::FRAME_W-1:0] f;
		logic [3:0]                  n;
		logic                        p;
		f = '1;
		n = 4'(utx_pkg::WORD_BASE) + {2'b00, c.word_len};
		p = 1'b0;
		f[0] = 1'b0; // Start bit [R04]
		for (int i = 0; i < 8; i++)
		begin
			if (4'(i) < n)
			begin
				f[i + 1] = d[i]; // Bit zero first [R05]
				p        = p ^ d[i];
			end
		end
		if (c.parity_en)
		begin
			// Stick parity forces the bit, else odd or even sense
			f[n + 4'h1] = c.stick_par ? ~c.even_par : (c.even_par ? p : ~p); // [R04]
		end
		return f;
	endfunction

	// Frame length in bits including start and stops
	function automatic logic [3:0] frame_bits(input utx_pkg::utx_cfg_t c);
		return 4'h1 + 4'(utx_pkg::WORD_BASE) + {2'b00, c.word_len}
			+ {3'b000, c.parity_en} + (c.stop2 ? 4'h2 : 4'h1); // [R04]
	endfunction

	// Strobe decode; holding register shares offset with divisor latch
	assign holding_wr = wr_en && addr == utx_pkg::OFF_HOLDING && !cfg.dlab;
	assign fifo_empty = count_r == '0;
	// Writes into a full FIFO are simply dropped [R23]
	assign fifo_push  = cfg.fifo_en && holding_wr && count_r < (AW+1)'(DEPTH); // [R02] [R09]
	assign fifo_pop   = cfg.fifo_en && !holding_full_r && !fifo_empty; // [R02]
	assign shift_load = state_r == utx_pkg::TX_IDLE && holding_full_r;
	assign tick_last  = cfg.sample_8x ? utx_pkg::TICKS_8X_LAST : utx_pkg::TICKS_16X_LAST;
	assign bit_end    = baud_tick && tick_cnt_r == tick_last; // [R03]
	assign flow_rd    = rd_en && addr == utx_pkg::OFF_STOP1;
	// Count wider than the register: clamp at 255 [R24]
	assign fill_sat   = count_r > (AW+1)'(8'hFF) ? 8'hFF : 8'(count_r);

	// FIFO storage, no reset needed on the array
	always_ff @(posedge mclk)
	begin
		if (fifo_push)
			fifo_mem[wr_ptr_r] <= wdata; // [R01]
	end

	// FIFO pointers step on every push and pop; count holds when both coincide
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else if (cfg.tx_fifo_rst)
		begin
			// Reset discards everything queued
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (fifo_push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (fifo_pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (fifo_push && !fifo_pop)
				count_r <= count_r + 1'b1; // [R24]
			else if (fifo_pop && !fifo_push)
				count_r <= count_r - 1'b1; // [R24]
		end
	end

	// Holding register: direct write or loaded from FIFO
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_holding_reg_r <= utx_pkg::RST_BYTE;
			holding_full_r   <= 1'b0;
		end
		else if (!cfg.fifo_en && holding_wr)
		begin
			// A write overruns an unsent byte, as on classic parts
			tx_holding_reg_r <= wdata; // [R02]
			holding_full_r   <= 1'b1;
		end
		else if (fifo_pop)
		begin
			tx_holding_reg_r <= fifo_mem[rd_ptr_r]; // [R02]
			holding_full_r   <= 1'b1;
		end
		else if (shift_load)
			holding_full_r <= 1'b0; // Empty flag rises on transfer [R06]
	end

	// Shifter state machine; bits advance on sampling-clock ticks
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r        <= utx_pkg::TX_IDLE;
			tx_shift_reg_r <= '1;
			bits_left_r    <= '0;
		end
		else
		begin
			unique case (state_r)
				utx_pkg::TX_IDLE:
				begin
					if (shift_load)
					begin
						tx_shift_reg_r <= build_frame(tx_holding_reg_r, cfg); // [R01]
						bits_left_r    <= frame_bits(cfg);
						state_r        <= utx_pkg::TX_SHIFT;
					end
				end
				utx_pkg::TX_SHIFT:
				begin
					if (bit_end)
					begin
						tx_shift_reg_r <= {1'b1, tx_shift_reg_r[utx_pkg::FRAME_W-1:1]}; // [R05]
						bits_left_r    <= bits_left_r - 1'b1;
						// Idle only after the last stop bit ends [R07]
						if (bits_left_r == 4'h1)
							state_r <= utx_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end

	// Tick counter: restarts at each frame, free-runs for turn-around
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tick_cnt_r <= '0;
		else if (shift_load)
			tick_cnt_r <= '0;
		else if (baud_tick)
			tick_cnt_r <= (tick_cnt_r == tick_last) ? 4'h0 : tick_cnt_r + 1'b1; // [R03]
	end

	// Serial output, break forces space; loopback parks the line at mark
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			txd_r <= 1'b1;
		else
			txd_r <= cfg.set_break ? 1'b0
				: (state_r == utx_pkg::TX_SHIFT ? tx_shift_reg_r[0] : 1'b1);
	end

	// Spare bits reach only the loopback path, never a pin
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			loop_spare_r <= 2'b00;
		else
			loop_spare_r <= cfg.loopback ? cfg.spare_out : 2'b00; // [R19]
	end

	// Half-duplex direction: on at load, off after delay past last stop
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dir_active_r <= 1'b0;
			dly_cnt_r    <= '0;
		end
		else if (!cfg.half_duplex)
		begin
			dir_active_r <= 1'b0;
			dly_cnt_r    <= '0;
		end
		else if (shift_load || state_r == utx_pkg::TX_SHIFT
			|| holding_full_r || !fifo_empty)
		begin
			// More to send: hold transmit state [R13]
			dir_active_r <= dir_active_r | shift_load;
			dly_cnt_r    <= '0;
		end
		else if (dir_active_r)
		begin
			// Count whole bit times after the final stop bit [R20]
			if (dly_cnt_r >= cfg.dir_delay)
				dir_active_r <= 1'b0;
			else if (bit_end)
				dly_cnt_r <= dly_cnt_r + 1'b1;
		end
	end

	// Register writes; enhanced feature bits are writable at any time
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			efc_r          <= utx_pkg::RST_BYTE;
			tx_threshold_r <= utx_pkg::RST_BYTE;
			rx_threshold_r <= utx_pkg::RST_BYTE;
			stop1_r        <= utx_pkg::RST_BYTE;
			stop2_r        <= utx_pkg::RST_BYTE;
			resume1_r      <= utx_pkg::RST_BYTE;
			resume2_r      <= utx_pkg::RST_BYTE;
		end
		else if (wr_en)
		begin
			unique case (addr)
				utx_pkg::OFF_EFC:      efc_r          <= wdata; // [R14]
				utx_pkg::OFF_TX_LEVEL: tx_threshold_r <= wdata; // [R14]
				utx_pkg::OFF_RX_LEVEL: rx_threshold_r <= wdata; // [R14]
				utx_pkg::OFF_STOP1:    stop1_r        <= wdata; // [R15]
				utx_pkg::OFF_STOP2:    stop2_r        <= wdata; // [R15]
				utx_pkg::OFF_RESUME1:  resume1_r      <= wdata; // [R15]
				utx_pkg::OFF_RESUME2:  resume2_r      <= wdata; // [R15]
				default:               ; // Lower map lives elsewhere
			endcase
		end
	end

	// Sticky flow indicators: a new event beats the read clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			flow_flags_r <= utx_pkg::RST_FLAGS;
		else
			flow_flags_r <= (flow_rd ? utx_pkg::RST_FLAGS : flow_flags_r) | flow_ev; // [R16]
	end

	// Read data, registered; unmapped offsets return zero
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= utx_pkg::RST_BYTE;
		else if (rd_en)
		begin
			unique case (addr)
				utx_pkg::OFF_EFC:      rdata_r <= efc_r;          // [R14]
				utx_pkg::OFF_TX_LEVEL: rdata_r <= fill_sat;       // [R14] [R24]
				utx_pkg::OFF_RX_LEVEL: rdata_r <= rx_fill_count;  // [R14]
				utx_pkg::OFF_STOP1:    rdata_r <= {utx_pkg::FLAG_ZERO, flow_flags_r}; // [R15] [R16]
				default:               rdata_r <= utx_pkg::RST_BYTE;
			endcase
		end
	end

	// Status flags, depending on FIFO mode
	assign thr_empty = cfg.fifo_en ? fifo_empty : !holding_full_r; // [R06] [R10]
	// Whole path empty: FIFO, holding and shifter [R07] [R22]
	assign tsr_empty = state_r == utx_pkg::TX_IDLE && !holding_full_r && fifo_empty;

	// Transmit-empty interrupt source selection
	always_comb
	begin
		if (cfg.half_duplex)
			tx_int = cfg.ier_tx_empty && tsr_empty; // [R12] [R08]
		else if (cfg.fifo_en)
			tx_int = cfg.ier_tx_empty && fill_sat < tx_threshold_r; // [R11] [R08]
		else
			tx_int = cfg.ier_tx_empty && !holding_full_r; // [R08]
	end

	// Outputs
	assign rdata              = rdata_r;
	assign txd                = cfg.loopback ? 1'b1 : txd_r;
	assign loop_txd           = txd_r;
	assign loop_spare         = loop_spare_r;
	assign dir_out            = dir_active_r ^ cfg.dir_invert; // [R21]
	assign enh_enable         = efc_r[utx_pkg::EFC_ENHANCED]; // [R17]
	assign auto_cts_en        = efc_r[utx_pkg::EFC_AUTO_CTS]; // [R18]
	assign auto_rts_en        = efc_r[utx_pkg::EFC_AUTO_RTS]; // [R18]
	assign special_char_en    = efc_r[utx_pkg::EFC_SPECIAL];  // [R18]
	assign sw_flow_mode       = efc_r[utx_pkg::EFC_SWFLOW_MSB:0]; // [R18]
	assign rx_fifo_threshold  = rx_threshold_r;
	assign stop_char_first    = stop1_r;
	assign stop_char_second   = stop2_r;
	assign resume_char_first  = resume1_r;
	assign resume_char_second = resume2_r;

endmodule // utx_core

// >>> rtl/utx_pkg.sv
// Package: constants and carrier types for the UART transmit path block
package utx_pkg;

	// Register offsets on the A3-A0 address bus
	localparam logic [3:0] OFF_HOLDING   = 4'h0; // Holding register write
	localparam logic [3:0] OFF_EFC       = 4'h9; // Enhanced feature control
	localparam logic [3:0] OFF_TX_LEVEL  = 4'hA; // Tx fill count / threshold
	localparam logic [3:0] OFF_RX_LEVEL  = 4'hB; // Rx fill count / threshold
	localparam logic [3:0] OFF_STOP1     = 4'hC; // Stop char 1 / flow status
	localparam logic [3:0] OFF_STOP2     = 4'hD; // Stop char 2
	localparam logic [3:0] OFF_RESUME1   = 4'hE; // Resume char 1
	localparam logic [3:0] OFF_RESUME2   = 4'hF; // Resume char 2

	// Enhanced feature control fields
	localparam int EFC_AUTO_CTS   = 7; // Automatic CTS/DSR flow control
	localparam int EFC_AUTO_RTS   = 6; // Automatic RTS/DTR flow control
	localparam int EFC_SPECIAL    = 5; // Special character detect
	localparam int EFC_ENHANCED   = 4; // Unlocks enhanced bits elsewhere
	localparam int EFC_SWFLOW_MSB = 3; // Software flow mode [3:0]

	// Reset values
	localparam logic [7:0] RST_BYTE  = 8'h00; // Generic register reset
	localparam logic [3:0] RST_FLAGS = 4'h0;  // Flow status reset

	// Sampling clock ticks per bit
	localparam logic [3:0] TICKS_16X_LAST = 4'hF; // 16 ticks per bit
	localparam logic [3:0] TICKS_8X_LAST  = 4'h7; // 8 ticks per bit

	// Frame layout
	localparam int FRAME_W   = 12;       // Start + 8 data + parity + 2 stop
	localparam int WORD_BASE = 5;        // Word length code 0 means 5 bits
	localparam logic [3:0] FLAG_ZERO = 4'h0; // Upper bits of flow status

	// Transmitter states
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b01,
		TX_SHIFT = 2'b10
	} utx_state_t;

	// Line and mode settings held by neighbouring registers
	typedef struct packed {
		logic       fifo_en;      // FIFO enable control bit 0
		logic       tx_fifo_rst;  // Tx FIFO reset pulse
		logic       ier_tx_empty; // Tx empty interrupt enable bit 1
		logic       dlab;         // Divisor latch access
		logic [1:0] word_len;     // Word length code
		logic       stop2;        // Two stop bits
		logic       parity_en;    // Parity enable
		logic       even_par;     // Even parity
		logic       stick_par;    // Forced parity
		logic       set_break;    // Hold line low
		logic       sample_8x;    // 8X instead of 16X sampling
		logic       half_duplex;  // Auto half-duplex enable
		logic [3:0] dir_delay;    // Turn-around delay in bit times
		logic       dir_invert;   // Direction polarity invert
		logic       loopback;     // Internal loopback
		logic [1:0] spare_out;    // Spare output bits two and one
	} utx_cfg_t;

	// One-cycle flow control events from the flow logic
	typedef struct packed {
		logic resume_sent;  // Bit 3
		logic stop_sent;    // Bit 2
		logic resume_det;   // Bit 1
		logic stop_det;     // Bit 0
	} utx_flow_ev_t;

endpackage : utx_pkg

// >>> tb/utx_core_sva.sv
// Checker for the transmit path: register effects, flags and direction
module utx_core_sva (
	input wire logic              mclk,
	input wire logic              rst_n,
	input wire logic [3:0]        addr,
	input wire logic              wr_en,
	input wire logic              rd_en,
	input wire logic [7:0]        wdata,
	input wire logic [7:0]        rdata,
	input wire utx_pkg::utx_cfg_t cfg,
	input wire logic              loop_txd,
	input wire logic [1:0]        loop_spare,
	input wire logic              dir_out,
	input wire logic              thr_empty,
	input wire logic              tsr_empty,
	input wire logic              tx_int,
	input wire logic              enh_enable,
	input wire logic              auto_cts_en,
	input wire logic              auto_rts_en,
	input wire logic              special_char_en,
	input wire logic [3:0]        sw_flow_mode,
	input wire logic [7:0]        stop_char_second
);
	timeunit 1ns;
	timeprecision 1ns;
	// One domain, so one clock and one disable for all
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// Feature byte lands on its mode outputs
	a_efc_fields: assert property (
		wr_en && addr == utx_pkg::OFF_EFC |=> {auto_cts_en, auto_rts_en,
		special_char_en, enh_enable, sw_flow_mode} == $past(wdata))
		else $error("feature outputs differ from written byte");
	// Second stop character takes the written byte
	a_char_write: assert property (
		wr_en && addr == utx_pkg::OFF_STOP2 |=> stop_char_second == $past(wdata))
		else $error("stop character two not written");
	// Flow status upper nibble always reads zero
	a_flow_upper: assert property (
		rd_en && addr == utx_pkg::OFF_STOP1 |=> rdata[7:4] == 4'h0)
		else $error("flow status upper bits not zero");
	// Interrupt silent while its enable is off
	a_int_mask: assert property (
		!cfg.ier_tx_empty |-> !tx_int)
		else $error("interrupt raised while disabled");
	// Non-FIFO: interrupt follows holding empty
	a_int_thr: assert property (
		cfg.ier_tx_empty && !cfg.fifo_en && !cfg.half_duplex |-> tx_int == thr_empty)
		else $error("interrupt does not follow holding empty");
	// Half-duplex: interrupt follows whole path empty
	a_int_tsr: assert property (
		cfg.ier_tx_empty && cfg.half_duplex |-> tx_int == tsr_empty)
		else $error("interrupt does not follow shifter empty");
	// Path empty implies nothing held either
	a_path_empty: assert property (
		tsr_empty |-> thr_empty)
		else $error("path empty while holding full");
	// Line idles high once everything is sent
	a_idle_high: assert property (
		tsr_empty && !cfg.set_break |-> loop_txd)
		else $error("line low while path empty");
	// Direction stays active while a frame bit drives the line low
	a_dir_frame: assert property (
		!loop_txd && !cfg.set_break && cfg.half_duplex |-> dir_out != cfg.dir_invert)
		else $error("direction inactive during frame");
	// Spare bits reach nothing outside loopback
	a_spare_zero: assert property (
		!cfg.loopback && $past(!cfg.loopback) |-> loop_spare == 2'h0)
		else $error("spare bits driven outside loopback");
endmodule // utx_core_sva

bind utx_core utx_core_sva u_sva (
	.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
	.wdata(wdata), .rdata(rdata), .cfg(cfg), .loop_txd(loop_txd),
	.loop_spare(loop_spare), .dir_out(dir_out), .thr_empty(thr_empty),
	.tsr_empty(tsr_empty), .tx_int(tx_int), .enh_enable(enh_enable),
	.auto_cts_en(auto_cts_en), .auto_rts_en(auto_rts_en),
	.special_char_en(special_char_en), .sw_flow_mode(sw_flow_mode),
	.stop_char_second(stop_char_second)
);

// >>> tb/utx_remote_station.sv
// Remote serial station: decodes frames seen on the line
module utx_remote_station (
	input  wire logic              mclk,
	input  wire logic              baud_tick,
	input  wire logic              txd,
	input  wire utx_pkg::utx_cfg_t cfg,
	output logic [7:0]             rx_byte,
	output int                     rx_count,
	output int                     rx_err
);
	timeunit 1ns;
	timeprecision 1ns;
	int         bt; // Ticks per bit
	logic [7:0] d;  // Assembled data

	// Waits a number of sampling ticks
	task automatic ticks(input int n);
		repeat (n) @(posedge mclk iff baud_tick);
	endtask

	// Samples mid-bit; fixed 8 data bits, so other word lengths go unchecked
	initial
	begin
		rx_count = 0;
		rx_err = 0;
		rx_byte = 8'h00;
		forever
		begin
			@(negedge txd);
			bt = cfg.sample_8x ? 8 : 16;
			ticks(bt / 2);
			if (txd !== 1'b0)
				rx_err++;
			for (int i = 0; i < 8; i++)
			begin
				ticks(bt);
				d[i] = txd; // Least significant first
			end
			if (cfg.parity_en)
			begin
				ticks(bt);
				if (txd !== (^d ^ !cfg.even_par)) // Parity only when enabled
					rx_err++;
			end
			repeat (cfg.stop2 ? 2 : 1)
			begin
				ticks(bt);
				if (txd !== 1'b1) // Stop bits high
					rx_err++;
			end
			rx_byte = d;
			rx_count++;
		end
	end
endmodule // utx_remote_station

// >>> tb/utx_core_tb.sv
// Self-checking bench for the transmit path block
module utx_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  mclk, rst_n, wr_en, rd_en, baud_tick, baud_en;
	logic [3:0]            addr;     // Register offset
	logic [7:0]            wdata;    // Write data
	logic [7:0]            rdata;    // Read data
	logic [7:0]            rx_fill;  // Receiver level
	utx_pkg::utx_cfg_t     cfg;      // Neighbour settings
	utx_pkg::utx_flow_ev_t flow_ev;  // Flow event pulses
	logic                  txd, loop_txd, dir_out, thr_empty, tsr_empty, tx_int;
	logic                  enh_en, cts_en, rts_en, spc_en;
	logic [1:0]            spare;    // Loopback spares
	logic [3:0]            sw_mode;  // Software flow mode
	logic [7:0]            rx_thr, sc1, sc2, rc1, rc2;
	logic [7:0]            rx_byte;  // Last decoded byte
	int                    rx_count, rx_err, miscompares, compares, bdiv, bcnt;

	utx_core dut_u (
		.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
		.wdata(wdata), .rdata(rdata), .cfg(cfg), .flow_ev(flow_ev),
		.rx_fill_count(rx_fill), .baud_tick(baud_tick), .txd(txd),
		.loop_txd(loop_txd), .loop_spare(spare), .dir_out(dir_out),
		.thr_empty(thr_empty), .tsr_empty(tsr_empty), .tx_int(tx_int),
		.enh_enable(enh_en), .auto_cts_en(cts_en), .auto_rts_en(rts_en),
		.special_char_en(spc_en), .sw_flow_mode(sw_mode), .rx_fifo_threshold(rx_thr),
		.stop_char_first(sc1), .stop_char_second(sc2), .resume_char_first(rc1),
		.resume_char_second(rc2)
	);
	utx_remote_station far_u (
		.mclk(mclk), .baud_tick(baud_tick), .txd(txd), .cfg(cfg),
		.rx_byte(rx_byte), .rx_count(rx_count), .rx_err(rx_err)
	);

	// Clock, 40 ns period
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Sampling tick every bdiv cycles; stoppable to stall the shifter
	always @(posedge mclk)
	begin
		#1;
		bcnt = (bcnt + 1) % bdiv;
		baud_tick = baud_en && (bcnt == 0);
	end

	task automatic report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		compares++;
		if (!ok)
		begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// Steps just past the next rising edge
	task automatic cyc;
		@(posedge mclk);
		#1;
	endtask
	// Idle edge first, so strobes never toggle twice in one step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cyc;
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		cyc;
		wr_en = 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		cyc;
		addr = a;
		rd_en = 1'b1;
		cyc;
		rd_en = 1'b0;
		chk(rdata === e, "read value");
	endtask
	task automatic wait_rx(input int k);
		int n;
		n = 0;
		while (rx_count < k && n < 800)
		begin
			cyc;
			n++;
		end
		chk(rx_count >= k, "frame missing");
	endtask
	task automatic wait_tsr(output int n);
		n = 0;
		while (tsr_empty !== 1'b1 && n < 3000)
		begin
			cyc;
			n++;
		end
	endtask

	// Reset values, map, write-only places, clear-on-read status
	task automatic t_regs;
		rd_chk(utx_pkg::OFF_EFC, 8'h00);
		wr(utx_pkg::OFF_EFC, 8'hA5);
		rd_chk(utx_pkg::OFF_EFC, 8'hA5);
		chk({cts_en, rts_en, spc_en, enh_en, sw_mode} === 8'hA5, "feature");
		rx_fill = 8'h3C;
		rd_chk(utx_pkg::OFF_RX_LEVEL, 8'h3C);
		wr(utx_pkg::OFF_RX_LEVEL, 8'h5A);
		chk(rx_thr === 8'h5A, "rx threshold");
		wr(utx_pkg::OFF_STOP1, 8'h11);
		wr(utx_pkg::OFF_STOP2, 8'h22);
		wr(utx_pkg::OFF_RESUME1, 8'h33);
		wr(utx_pkg::OFF_RESUME2, 8'h44);
		chk({sc1, sc2, rc1, rc2} === 32'h11223344, "flow chars");
		rd_chk(utx_pkg::OFF_STOP1, 8'h00);
		wr(4'h7, 8'hFF);
		rd_chk(4'h7, 8'h00);
		cyc;
		flow_ev = 4'hF;
		cyc;
		flow_ev = 4'h0;
		rd_chk(utx_pkg::OFF_STOP1, 8'h0F);
		rd_chk(utx_pkg::OFF_STOP1, 8'h00);
		// Spares show only on the loopback path, line parked at mark
		cfg.loopback = 1'b1;
		cfg.spare_out = 2'h2;
		repeat (2) cyc;
		chk(spare === 2'h2 && txd === 1'b1, "loop spares");
		cfg.loopback = 1'b0;
		repeat (2) cyc;
		chk(spare === 2'h0, "spares off");
		cfg.spare_out = 2'h0;
	endtask
	// Single frame, non-FIFO: flags, bit timing, framing
	task automatic t_frame(input logic p, s, x, input logic [7:0] b);
		int n, ex, base;
		base = rx_count;
		cfg.parity_en = p;
		cfg.stop2 = s;
		cfg.sample_8x = x;
		ex = (10 + p + s) * (x ? 8 : 16) * bdiv;
		wr(utx_pkg::OFF_HOLDING, b);
		chk(thr_empty === 1'b0 && tsr_empty === 1'b0, "busy");
		repeat (3) cyc;
		chk(thr_empty === 1'b1 && tsr_empty === 1'b0, "moved");
		wait_tsr(n);
		chk(n >= ex - 5 && n <= ex + 2 * bdiv + 1, "frame time");
		chk(rx_count === base + 1 && rx_byte === b, "byte");
	endtask
	// FIFO filled with shifter stalled, overflow, then full drain
	task automatic t_full;
		int i, n, base;
		base = rx_count;
		cfg.fifo_en = 1'b1;
		cfg.sample_8x = 1'b1;
		cfg.parity_en = 1'b0;
		cfg.stop2 = 1'b0;
		baud_en = 1'b0;
		bdiv = 1;
		wr(utx_pkg::OFF_TX_LEVEL, 8'h04);
		for (i = 0; i < 258; i++)
			wr(utx_pkg::OFF_HOLDING, i[7:0]);
		wr(utx_pkg::OFF_HOLDING, 8'hEE);
		rd_chk(utx_pkg::OFF_TX_LEVEL, 8'hFF);
		chk(tx_int === 1'b0 && thr_empty === 1'b0, "full flags");
		baud_en = 1'b1;
		for (i = 0; i < 258; i++)
		begin
			wait_rx(base + i + 1);
			chk(rx_byte === i[7:0], "fifo order");
		end
		wait_tsr(n);
		rd_chk(utx_pkg::OFF_TX_LEVEL, 8'h00);
		chk(thr_empty === 1'b1 && tx_int === 1'b1, "drained");
		chk(rx_count === base + 258, "no extra byte");
	endtask
	// Half-duplex: interrupt source, held then released direction
	task automatic t_hdx;
		int n;
		cfg.fifo_en = 1'b0;
		cfg.sample_8x = 1'b0;
		bdiv = 2;
		cfg.half_duplex = 1'b1;
		cfg.dir_invert = 1'b1;
		cfg.dir_delay = 4'h2;
		wr(utx_pkg::OFF_HOLDING, 8'h3C);
		repeat (4) cyc;
		chk(thr_empty === 1'b1 && tx_int === 1'b0, "int source");
		wait_tsr(n);
		chk(dir_out === 1'b0 && tx_int === 1'b1, "dir held");
		n = 0;
		while (dir_out !== 1'b1 && n < 300)
		begin
			cyc;
			n++;
		end
		chk(n >= 33 && n <= 68, "turnaround");
	endtask

	// Watchdog well beyond the expected 22k cycles
	initial
	begin
		#(60000 * 40);
		miscompares++;
		report_and_stop;
	end
	initial
	begin
		rst_n = 1'b0;
		addr = 4'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = 8'h00;
		rx_fill = 8'h00;
		flow_ev = 4'h0;
		cfg = '0;
		cfg.word_len = 2'h3;
		baud_en = 1'b1;
		bdiv = 2;
		bcnt = 0;
		baud_tick = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (12) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		t_regs;
		cfg.ier_tx_empty = 1'b1;
		cfg.even_par = 1'b1;
		t_frame(1'b0, 1'b0, 1'b0, 8'hA5);
		t_frame(1'b1, 1'b1, 1'b1, 8'h96);
		t_full;
		t_hdx;
		chk(rx_err === 0, "remote saw bad frame");
		report_and_stop;
	end
endmodule // utx_core_tb
